// File: uvoc_host.sv
// host model issuing byte and word commands
module uvoc_host (
    input  wire logic        clk_i,
    input  wire logic        resp_valid_i,
    input  wire logic        resp_nack_i,
    input  wire logic [15:0] resp_rdata_i,
    output logic             cmd_valid_o,
    output logic             cmd_write_o,
    output logic [7:0]       cmd_code_o,
    output logic [15:0]      cmd_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o  = 8'h00;
        cmd_data_o  = 16'h0000;
    end
    // one-cycle command, code and data lines scrambled once released
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic n, output logic [15:0] r);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_write_o <= w;
        cmd_code_o  <= c;
        cmd_data_o  <= d;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o  <= ~c;
        cmd_data_o  <= ~d;
        #1;
        for (int k = 0; k < 4 && !resp_valid_i; k++)
            @(posedge clk_i) #1;
        n = resp_valid_i ? resp_nack_i : 1'bx;
        r = resp_rdata_i;
    endtask : xfer
endmodule : uvoc_host

// File: uvoc_map.svh
// register offsets, field positions, reset values and timing figures
`ifndef UVOC_MAP_SVH
`define UVOC_MAP_SVH
`define UVOC_CMD_UV_ACT   8'h45
`define UVOC_CMD_OC_LIM   8'h46
`define UVOC_UV_B_ZERO    7
`define UVOC_UV_B_ACTN    6
`define UVOC_UV_B_RS_HI   5
`define UVOC_UV_B_RS_LO   3
`define UVOC_UV_B_TD_HI   1
`define UVOC_OC_B_EXP_LO  11
`define UVOC_OC_B_PH7     7
`define UVOC_OC_B_PH6     6
`define UVOC_OC_B_CODE_HI 5
`define UVOC_RST_ACTN     1'b1
`define UVOC_RST_RETRY    3'h0
`define UVOC_RST_DELAY    2'h0
`define UVOC_RST_OCLIM    8'h00
`define UVOC_RETRY_LATCH  3'h0
`define UVOC_RETRY_AUTO   3'h7
`define UVOC_OC_EXP_HALF  5'h1f
`define UVOC_OC_EXP_ONE   5'h00
`define UVOC_OC_RSVD      3'h0
`define UVOC_CNT_W        23
`define UVOC_CLK_NS       10
`define UVOC_TD_2US_NS    2000
`define UVOC_TD_16US_NS   16000
`define UVOC_TD_64US_NS   64000
`define UVOC_HICCUP_MS    52
`define UVOC_TD_2US_CYC   (`UVOC_TD_2US_NS / `UVOC_CLK_NS)
`define UVOC_TD_16US_CYC  (`UVOC_TD_16US_NS / `UVOC_CLK_NS)
`define UVOC_TD_64US_CYC  (`UVOC_TD_64US_NS / `UVOC_CLK_NS)
`define UVOC_HICCUP_CYC   (`UVOC_HICCUP_MS * 1000000 / `UVOC_CLK_NS)
`endif

// File: uvoc_pkg.sv
// types of the undervoltage response and overcurrent limit block
package uvoc_pkg;
    typedef enum logic [1:0] {
        uvoc_run,
        uvoc_wait,
        uvoc_latch,
        uvoc_hiccup
    } uvoc_state_e;

    typedef struct packed {
        uvoc_state_e state;
        logic [22:0] cnt;
        logic        act_n;
        logic [2:0]  retry;
        logic [1:0]  delay;
        logic [7:0]  oc_lim;
        logic        ign_pend;
        logic        uv_flag;
        logic        cml_flag;
        logic        ivd_flag;
        logic        oc_fault;
        logic        resp_valid;
        logic        resp_nack;
        logic [15:0] rdata;
    } uvoc_regs_s;
endpackage : uvoc_pkg

// File: uvoc_regs.sv
// undervoltage fault response and valley overcurrent limit command registers
// Summary of operation
// (R1) uv fault sets three status flags and alert
// (R2) response register is byte at 45h
// (R3) bit 7 reads 0; writing 1 nacks, ivd
// (R4) active-low act bit 0 ignores the fault
// (R5) act bit 1: wait delay, then retry action
// (R6) earlier ignored fault acted on when enabled
// (R7) retry 000b latches off until enable toggle
// (R8) retry 111b restarts after 52 ms hiccup
// (R9) other retry codes rejected as invalid data
// (R10) restore copies stored bit 5 to all three
// (R11) delay codes select 2, 16, 64 us
// (R12) fault gone early resets counter, output stays
// (R13) delay bit 2 reads 0, writes ignored
// (R14) limit register is word at 46h
// (R15) valley current compared against programmed threshold
// (R16) exponent read-only, 0.5 A or 1 A step
// (R17) limit bits 10:8 always read zero
// (R18) bit 7 writable only above two phases
// (R19) bit 6 writable only above one phase
// (R20) code bits writable and restored at startup
// (R21) uv detection only after soft-start done
// (R22) read-only limit change nacks, sets cml, ivd
// (R23) clear faults drops record and status flags
// (R24) delay code 011b uses longest delay
`include "uvoc_map.svh"

module uvoc_regs #(
    parameter logic [`UVOC_CNT_W-1:0] DLY64_CYC  = `UVOC_CNT_W'(`UVOC_TD_64US_CYC),
    parameter logic [`UVOC_CNT_W-1:0] HICCUP_CYC = `UVOC_CNT_W'(`UVOC_HICCUP_CYC)
) (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        cmd_valid_i,
    input  wire logic        cmd_write_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [15:0] cmd_data_i,
    output logic             resp_valid_o,
    output logic             resp_nack_o,
    output logic [15:0]      resp_rdata_o,
    input  wire logic        clear_faults_i,
    input  wire logic        nvm_load_i,
    input  wire logic [7:0]  nvm_uv_byte_i,
    input  wire logic [5:0]  nvm_oc_code_i,
    input  wire logic        enable_i,
    input  wire logic        soft_start_done_i,
    input  wire logic        uv_below_i,
    input  wire logic [1:0]  phase_count_i,
    input  wire logic        oc_lsb_half_i,
    input  wire logic [7:0]  valley_code_i,
    output logic             output_en_o,
    output logic             oc_fault_o,
    output logic             uv_fault_flag_o,
    output logic             vout_group_flag_o,
    output logic             vout_uv_flag_o,
    output logic             comm_error_flag_o,
    output logic             invalid_data_flag_o,
    output logic             alert_n_pin_o,
    output logic             alert_n_pin_oe_n_o
);

    uvoc_pkg::uvoc_regs_s r_reg;
    uvoc_pkg::uvoc_regs_s r_next;

    logic                   conv_on;
    logic                   uv_det;
    logic                   uv_cond;
    logic [4:0]             oc_exp;
    logic [15:0]            oc_rd;
    logic [7:0]             uv_rd;
    logic [`UVOC_CNT_W-1:0] dly_cyc;
    logic                   uv_bad;
    logic                   oc_bad;
    logic                   ph7_wr;
    logic                   ph6_wr;
    logic [7:0]             oc_wr;

    assign conv_on = (r_reg.state == uvoc_pkg::uvoc_run)
                  || (r_reg.state == uvoc_pkg::uvoc_wait);

    // detection only while converting and past soft-start
    assign uv_det  = uv_below_i && soft_start_done_i && conv_on; // (R21)
    assign uv_cond = uv_det || r_reg.ign_pend; // (R6)

    assign oc_exp = oc_lsb_half_i ? `UVOC_OC_EXP_HALF : `UVOC_OC_EXP_ONE; // (R16)
    assign oc_rd  = {oc_exp, `UVOC_OC_RSVD, r_reg.oc_lim}; // (R17)
    assign uv_rd  = {1'b0, r_reg.act_n, r_reg.retry, 1'b0, r_reg.delay}; // (R3) (R13)

    always_comb
    begin
        unique case (r_reg.delay) // (R11)
            2'h0:    dly_cyc = `UVOC_CNT_W'(`UVOC_TD_2US_CYC);
            2'h1:    dly_cyc = `UVOC_CNT_W'(`UVOC_TD_16US_CYC);
            default: dly_cyc = DLY64_CYC; // (R24)
        endcase
    end

    // byte write checks
    always_comb
    begin
        uv_bad = cmd_data_i[`UVOC_UV_B_ZERO]; // (R3)
        if ((cmd_data_i[`UVOC_UV_B_RS_HI:`UVOC_UV_B_RS_LO] != `UVOC_RETRY_LATCH)
            && (cmd_data_i[`UVOC_UV_B_RS_HI:`UVOC_UV_B_RS_LO] != `UVOC_RETRY_AUTO))
        begin
            uv_bad = 1'b1; // (R9)
        end
    end

    // word write checks against the phase-dependent access
    assign ph7_wr = (phase_count_i > 2'd2); // (R18)
    assign ph6_wr = (phase_count_i > 2'd1); // (R19)

    always_comb
    begin
        oc_bad = (cmd_data_i[15:8] != oc_rd[15:8]); // (R16) (R22)
        if (!ph7_wr && (cmd_data_i[`UVOC_OC_B_PH7] != r_reg.oc_lim[`UVOC_OC_B_PH7]))
        begin
            oc_bad = 1'b1; // (R18) (R22)
        end
        if (!ph6_wr && (cmd_data_i[`UVOC_OC_B_PH6] != r_reg.oc_lim[`UVOC_OC_B_PH6]))
        begin
            oc_bad = 1'b1; // (R19) (R22)
        end
        oc_wr = cmd_data_i[7:0]; // (R20)
    end

    always_comb
    begin
        r_next            = r_reg;
        r_next.resp_valid = 1'b0;
        r_next.resp_nack  = 1'b0;

        // clear first so a same-cycle set below wins
        if (clear_faults_i)
        begin
            r_next.uv_flag  = 1'b0; // (R23)
            r_next.cml_flag = 1'b0;
            r_next.ivd_flag = 1'b0;
            r_next.ign_pend = 1'b0; // (R23)
        end
        if (uv_det)
        begin
            r_next.uv_flag = 1'b1; // (R1)
        end
        if (uv_det && !r_reg.act_n)
        begin
            r_next.ign_pend = 1'b1; // (R4) (R6)
        end

        // nonvolatile restore
        if (nvm_load_i)
        begin
            r_next.act_n = nvm_uv_byte_i[`UVOC_UV_B_ACTN];
            r_next.retry = {3{nvm_uv_byte_i[`UVOC_UV_B_RS_HI]}}; // (R10)
            r_next.delay = nvm_uv_byte_i[`UVOC_UV_B_TD_HI:0];
            r_next.oc_lim[`UVOC_OC_B_CODE_HI:0] = nvm_oc_code_i; // (R20)
        end

        // host command, one answer per request
        if (cmd_valid_i)
        begin
            r_next.resp_valid = 1'b1;
            r_next.rdata      = 16'h0000;
            case (cmd_code_i)
                `UVOC_CMD_UV_ACT: // (R2)
                begin
                    if (!cmd_write_i)
                    begin
                        r_next.rdata = {8'h00, uv_rd};
                    end
                    else if (uv_bad)
                    begin
                        r_next.resp_nack = 1'b1; // (R3) (R9)
                        r_next.ivd_flag  = 1'b1;
                    end
                    else
                    begin
                        r_next.act_n = cmd_data_i[`UVOC_UV_B_ACTN];
                        r_next.retry = cmd_data_i[`UVOC_UV_B_RS_HI:`UVOC_UV_B_RS_LO];
                        r_next.delay = cmd_data_i[`UVOC_UV_B_TD_HI:0]; // (R13)
                    end
                end
                `UVOC_CMD_OC_LIM: // (R14)
                begin
                    if (!cmd_write_i)
                    begin
                        r_next.rdata = oc_rd;
                    end
                    else if (oc_bad)
                    begin
                        r_next.resp_nack = 1'b1; // (R22)
                        r_next.cml_flag  = 1'b1;
                        r_next.ivd_flag  = 1'b1;
                    end
                    else
                    begin
                        r_next.oc_lim = oc_wr; // (R20)
                    end
                end
                default:
                begin
                    r_next.resp_nack = 1'b1;
                    r_next.cml_flag  = 1'b1;
                end
            endcase
        end

        // fault response sequence
        unique case (r_reg.state)
            uvoc_pkg::uvoc_run:
            begin
                r_next.cnt = '0;
                if (r_reg.act_n && uv_cond)
                begin
                    r_next.state = uvoc_pkg::uvoc_wait; // (R5) (R6)
                end
            end
            uvoc_pkg::uvoc_wait:
            begin
                if (!r_reg.act_n || !uv_cond)
                begin
                    r_next.state = uvoc_pkg::uvoc_run; // (R4) (R12)
                    r_next.cnt   = '0; // (R12)
                end
                else if (r_reg.cnt >= dly_cyc - `UVOC_CNT_W'(1))
                begin
                    r_next.cnt      = '0;
                    r_next.ign_pend = 1'b0;
                    if (r_reg.retry == `UVOC_RETRY_AUTO)
                    begin
                        r_next.state = uvoc_pkg::uvoc_hiccup; // (R8)
                    end
                    else
                    begin
                        r_next.state = uvoc_pkg::uvoc_latch; // (R7)
                    end
                end
                else
                begin
                    r_next.cnt = r_reg.cnt + `UVOC_CNT_W'(1); // (R5)
                end
            end
            uvoc_pkg::uvoc_latch:
            begin
                // only an enable toggle or bias loss restarts
                if (!enable_i)
                begin
                    r_next.state = uvoc_pkg::uvoc_run; // (R7)
                end
            end
            uvoc_pkg::uvoc_hiccup:
            begin
                if (!enable_i || (r_reg.cnt >= HICCUP_CYC - `UVOC_CNT_W'(1)))
                begin
                    r_next.state = uvoc_pkg::uvoc_run; // (R8)
                    r_next.cnt   = '0;
                end
                else
                begin
                    r_next.cnt = r_reg.cnt + `UVOC_CNT_W'(1); // (R8)
                end
            end
        endcase

        // valley current against programmed threshold
        r_next.oc_fault = conv_on && (valley_code_i >= r_reg.oc_lim); // (R15)
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            r_reg            <= '0;
            r_reg.state      <= uvoc_pkg::uvoc_run;
            r_reg.act_n      <= `UVOC_RST_ACTN; // (R4)
            r_reg.retry      <= `UVOC_RST_RETRY;
            r_reg.delay      <= `UVOC_RST_DELAY;
            r_reg.oc_lim     <= `UVOC_RST_OCLIM;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign resp_valid_o        = r_reg.resp_valid;
    assign resp_nack_o         = r_reg.resp_nack;
    assign resp_rdata_o        = r_reg.rdata;
    assign output_en_o         = enable_i && conv_on; // (R4) (R7)
    assign oc_fault_o          = r_reg.oc_fault;
    assign uv_fault_flag_o     = r_reg.uv_flag; // (R1)
    assign vout_group_flag_o   = r_reg.uv_flag; // (R1)
    assign vout_uv_flag_o      = r_reg.uv_flag; // (R1)
    assign comm_error_flag_o   = r_reg.cml_flag;
    assign invalid_data_flag_o = r_reg.ivd_flag;

    // open-drain alert: pull low while any flag stands
    assign alert_n_pin_o       = 1'b0;
    assign alert_n_pin_oe_n_o  = !(r_reg.uv_flag || r_reg.cml_flag
                                  || r_reg.ivd_flag); // (R1)

endmodule : uvoc_regs

// File: uvoc_regs_assertions.sv
// port assertions of the uv response and oc limit block
module uvoc_regs_checker (
    input wire logic        core_clk_i,
    input wire logic        resetn_i,
    input wire logic        cmd_valid_i,
    input wire logic        cmd_write_i,
    input wire logic [7:0]  cmd_code_i,
    input wire logic [15:0] cmd_data_i,
    input wire logic        resp_valid_o,
    input wire logic        resp_nack_o,
    input wire logic        clear_faults_i,
    input wire logic        soft_start_done_i,
    input wire logic        uv_below_i,
    input wire logic        output_en_o,
    input wire logic        uv_fault_flag_o,
    input wire logic        alert_n_pin_oe_n_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    logic uv_wr;
    assign uv_wr = cmd_valid_i && cmd_write_i && cmd_code_i == 8'h45;
    property p_answer; cmd_valid_i |=> resp_valid_o; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_bit7; uv_wr && cmd_data_i[7] |=> resp_nack_o; endproperty
    a_bit7: assert property (p_bit7) else $error("bit 7 accepted");
    property p_retry; uv_wr && !(cmd_data_i[5:3] inside {3'h0, 3'h7}) |=> resp_nack_o;
    endproperty
    a_retry: assert property (p_retry) else $error("retry code accepted");
    property p_code; cmd_valid_i && !(cmd_code_i inside {8'h45, 8'h46}) |=> resp_nack_o;
    endproperty
    a_code: assert property (p_code) else $error("unknown code accepted");
    property p_alert; uv_fault_flag_o |-> !alert_n_pin_oe_n_o; endproperty
    a_alert: assert property (p_alert) else $error("alert not driven");
    property p_detect; uv_below_i && soft_start_done_i && output_en_o |=> uv_fault_flag_o;
    endproperty
    a_detect: assert property (p_detect) else $error("uv not flagged");
    property p_ss; !soft_start_done_i && !uv_fault_flag_o |=> !uv_fault_flag_o; endproperty
    a_ss: assert property (p_ss) else $error("uv flagged in ramp");
    property p_clear; clear_faults_i && !uv_below_i |=> !uv_fault_flag_o; endproperty
    a_clear: assert property (p_clear) else $error("uv flag kept");
    c_nack: cover property (resp_valid_o && resp_nack_o);
    c_off: cover property ($fell(output_en_o));
    c_uv: cover property ($rose(uv_fault_flag_o));
endmodule : uvoc_regs_checker

bind uvoc_regs uvoc_regs_checker uvoc_regs_checker_inst (
    .core_clk_i, .resetn_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_data_i,
    .resp_valid_o, .resp_nack_o, .clear_faults_i, .soft_start_done_i, .uv_below_i,
    .output_en_o, .uv_fault_flag_o, .alert_n_pin_oe_n_o
);

// File: uvoc_regs_tb_top.sv
// testbench of the uv response and oc limit block
module uvoc_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i, resetn_i, cmd_valid_i, cmd_write_i, clear_faults_i;
    logic        nvm_load_i, enable_i, soft_start_done_i, uv_below_i, oc_lsb_half_i;
    logic        resp_valid_o, resp_nack_o, output_en_o, oc_fault_o, uv_fault_flag_o;
    logic        vout_group_flag_o, vout_uv_flag_o, comm_error_flag_o;
    logic        invalid_data_flag_o, alert_n_pin_o, alert_n_pin_oe_n_o, n;
    logic [1:0]  phase_count_i;
    logic [5:0]  nvm_oc_code_i;
    logic [7:0]  cmd_code_i, nvm_uv_byte_i, valley_code_i;
    logic [15:0] cmd_data_i, resp_rdata_o, r;
    int          fail_count = 0;
    int          checked = 0;
    wire         alert_line = alert_n_pin_oe_n_o ? 1'b1 : alert_n_pin_o;

    uvoc_regs #(.DLY64_CYC(23'h28), .HICCUP_CYC(23'h32)) uvoc_regs_inst (
        .core_clk_i, .resetn_i, .cmd_valid_i, .cmd_write_i, .cmd_code_i, .cmd_data_i,
        .resp_valid_o, .resp_nack_o, .resp_rdata_o, .clear_faults_i, .nvm_load_i,
        .nvm_uv_byte_i, .nvm_oc_code_i, .enable_i, .soft_start_done_i, .uv_below_i,
        .phase_count_i, .oc_lsb_half_i, .valley_code_i, .output_en_o, .oc_fault_o,
        .uv_fault_flag_o, .vout_group_flag_o, .vout_uv_flag_o, .comm_error_flag_o,
        .invalid_data_flag_o, .alert_n_pin_o, .alert_n_pin_oe_n_o
    );
    uvoc_host uvoc_host_inst (
        .clk_i(core_clk_i), .resp_valid_i(resp_valid_o), .resp_nack_i(resp_nack_o),
        .resp_rdata_i(resp_rdata_o), .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i),
        .cmd_code_o(cmd_code_i), .cmd_data_o(cmd_data_i)
    );

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR %0t: saw %h, expected %h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic e);
        uvoc_host_inst.xfer(1'b1, c, d, n, r);
        chk(16'(n), 16'(e));
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        uvoc_host_inst.xfer(1'b0, c, 16'h0000, n, r);
        chk(r, e);
    endtask : rd
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask : cyc
    task automatic uvb(input logic v, input int k);
        @(posedge core_clk_i) uv_below_i <= v;
        cyc(k);
    endtask : uvb
    task automatic clr();
        @(posedge core_clk_i) clear_faults_i <= 1'b1;
        @(posedge core_clk_i) clear_faults_i <= 1'b0;
        cyc(1);
    endtask : clr
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    initial
    begin
        #300us;
        fail_count++;
        finish_test();
    end
    initial
    begin
        {resetn_i, clear_faults_i, nvm_load_i, uv_below_i, soft_start_done_i} = 5'h00;
        {enable_i, oc_lsb_half_i, phase_count_i} = 4'hd;
        nvm_oc_code_i = 6'h15;
        nvm_uv_byte_i = 8'h21;
        valley_code_i = 8'h00;
        repeat (5) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        rd(8'h45, 16'h0040);
        rd(8'h46, 16'hf800);
        @(posedge core_clk_i) oc_lsb_half_i <= 1'b0;
        rd(8'h46, 16'h0000);
        $display("reset values done");
        wr(8'h45, 16'h00c0, 1'b1);
        chk(16'(invalid_data_flag_o), 16'h0001);
        for (int i = 0; i < 8; i++)
            wr(8'h45, 16'(8'h40 | (i << 3)), 1'(i != 0 && i != 7));
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h45, 16'h0038 | 16'(i), 1'b0);
            rd(8'h45, 16'h0038 | 16'(i & 3));
        end
        wr(8'h46, 16'h0080, 1'b1);
        chk(16'(comm_error_flag_o), 16'h0001);
        wr(8'h47, 16'h0000, 1'b1);
        wr(8'h46, 16'h0040, 1'b1);
        wr(8'h46, 16'h0100, 1'b1);
        wr(8'h46, 16'h002a, 1'b0);
        rd(8'h46, 16'h002a);
        @(posedge core_clk_i) phase_count_i <= 2'h2;
        wr(8'h46, 16'h00ea, 1'b1);
        wr(8'h46, 16'h006a, 1'b0);
        @(posedge core_clk_i) phase_count_i <= 2'h3;
        wr(8'h46, 16'h00ea, 1'b0);
        rd(8'h46, 16'h00ea);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge core_clk_i) valley_code_i <= 8'he9 + 8'(i);
            cyc(3);
            chk(16'(oc_fault_o), 16'(i));
        end
        clr();
        chk(16'({comm_error_flag_o, invalid_data_flag_o, alert_line}), 16'h0001);
        $display("register access done");
        wr(8'h45, 16'h0040, 1'b0);
        uvb(1'b1, 5);
        chk(16'(uv_fault_flag_o), 16'h0000);
        @(posedge core_clk_i) soft_start_done_i <= 1'b1;
        cyc(196);
        chk(16'({uv_fault_flag_o, vout_group_flag_o, vout_uv_flag_o}), 16'h0007);
        chk(16'({alert_line, output_en_o}), 16'h0001);
        cyc(8);
        chk(16'(output_en_o), 16'h0000);
        uvb(1'b0, 20);
        clr();
        chk(16'({uv_fault_flag_o, output_en_o}), 16'h0000);
        @(posedge core_clk_i) enable_i <= 1'b0;
        @(posedge core_clk_i) enable_i <= 1'b1;
        cyc(2);
        chk(16'(output_en_o), 16'h0001);
        wr(8'h45, 16'h0041, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            uvb(1'b1, 1000);
            uvb(1'b0, 2);
        end
        chk(16'(output_en_o), 16'h0001);
        clr();
        wr(8'h45, 16'h0038, 1'b0);
        uvb(1'b1, 300);
        chk(16'(output_en_o), 16'h0001);
        uvb(1'b0, 1);
        wr(8'h45, 16'h0078, 1'b0);
        cyc(190);
        chk(16'(output_en_o), 16'h0001);
        cyc(20);
        chk(16'(output_en_o), 16'h0000);
        cyc(60);
        chk(16'(output_en_o), 16'h0001);
        wr(8'h45, 16'h0043, 1'b0);
        uvb(1'b1, 36);
        chk(16'(output_en_o), 16'h0001);
        cyc(8);
        chk(16'(output_en_o), 16'h0000);
        $display("fault response done");
        @(posedge core_clk_i) nvm_load_i <= 1'b1;
        @(posedge core_clk_i) nvm_load_i <= 1'b0;
        rd(8'h45, 16'h0039);
        rd(8'h46, 16'h00d5);
        $display("restore done");
        finish_test();
    end
endmodule : uvoc_regs_tb_top
